// ### hdl/flash_seq_pkg.sv
// Constants shared by the flash program and erase sequencer
package flash_seq_pkg;

	// Clock rate of clk_sys
	localparam int CLK_MHZ = 125;

	// Device register byte addresses
	localparam logic [23:0] ADDR_CTRL   = 24'hFFFF40;
	localparam logic [23:0] ADDR_SEL_LO = 24'hFFFF42;
	localparam logic [23:0] ADDR_SEL_HI = 24'hFFFF43;
	localparam logic [23:0] ADDR_WDOG   = 24'hFFFFA8;

	// Control register bit positions
	localparam int BIT_PROG = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_WCHK = 2;
	localparam int BIT_BCHK = 3;
	localparam int BIT_HV = 6;

	// Control register byte codes
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] CTRL_HV    = 8'h01 << BIT_HV;
	localparam logic [7:0] CTRL_PROG  = CTRL_HV | (8'h01 << BIT_PROG);
	localparam logic [7:0] CTRL_ERASE = CTRL_HV | (8'h01 << BIT_ERASE);
	localparam logic [7:0] CTRL_WCHK  = CTRL_HV | (8'h01 << BIT_WCHK);
	localparam logic [7:0] CTRL_BCHK  = CTRL_HV | (8'h01 << BIT_BCHK);

	// Watchdog words and fixed data bytes
	localparam logic [15:0] WDOG_START = 16'hA579;
	localparam logic [15:0] WDOG_STOP  = 16'hA500;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [7:0]  BYTE_BLANK = 8'hFF;

	// Times in ns as printed, and derived cycle counts
	localparam int T_HV_NS = 5000;
	localparam int T_WCHK_NS = 4000;
	localparam int T_BCHK_NS = 4000;
	localparam int T_DUMMY_NS = 2000;
	localparam int T_PROG_MAX_NS = 15800;
	localparam int T_PROG_TOTAL_NS = 1000000;
	localparam int T_HV_CYC = (T_HV_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WCHK_CYC = (T_WCHK_NS * CLK_MHZ + 999) / 1000;
	localparam int T_BCHK_CYC = (T_BCHK_NS * CLK_MHZ + 999) / 1000;
	localparam int T_DUMMY_CYC = (T_DUMMY_NS * CLK_MHZ + 999) / 1000;
	localparam int T_PROG_MAX_CYC = (T_PROG_MAX_NS * CLK_MHZ) / 1000;
	localparam int T_PROG_TOTAL_CYC = (T_PROG_TOTAL_NS * CLK_MHZ) / 1000;
	localparam int READ_SETTLE_CYC = 3;

	// Retry limits
	localparam int PV_MAX_TRIES = 6;
	localparam int ERASE_MAX_REPS = 602;

	// Timer width
	localparam int TMR_W = 20;

	// Software register byte offsets
	localparam logic [4:0] REG_CMD    = 5'h00;
	localparam logic [4:0] REG_START  = 5'h04;
	localparam logic [4:0] REG_END    = 5'h08;
	localparam logic [4:0] REG_DATA   = 5'h0C;
	localparam logic [4:0] REG_BLKSEL = 5'h10;
	localparam logic [4:0] REG_PPULSE = 5'h14;
	localparam logic [4:0] REG_EPULSE = 5'h18;
	localparam logic [4:0] REG_STATUS = 5'h1C;

	// Field positions and reset values
	localparam int CMD_GO = 0;
	localparam int CMD_ERASE = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam logic [15:0] PPULSE_RST = 16'h0100;
	localparam logic [15:0] EPULSE_RST = 16'h1000;

endpackage

// ### hdl/seq_wait_timer.sv
// Down-counting wait timer used for pulse lengths and settle waits
`timescale 1ns/1ps
`default_nettype none
module seq_wait_timer
	import flash_seq_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Load and expiry
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] count,
	output wire logic             done
);

	logic [TMR_W-1:0] cnt_q;

	// Count lands on one exactly count-1 cycles after the load edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done = (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1}) && !load;

endmodule
`default_nettype wire

// ### hdl/flash_seq_ctrl.sv
// Host sequencer that programs and erases the flash through its registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - Clear program bit before setting write check
// - Wait 4 us before write-check read
// - Match advances, mismatch reprograms
// - At most six pulses, total within 1 ms
// - Double pulse length after each failure
// - Control codes 40, 41, 44, then 00
// - Watchdog started before pulse, stopped after
// - Prewrite zeros before any erase
// - High voltage, wait 5 us, selects, erase
// - Erase split into short timed pulses
// - Clear erase, set blank check, wait 4 us
// - Dummy FF write before each blank read
// - Wait 2 us after dummy write
// - Failure repeats erase, at most 602 times
// - First program pulse at most 15.8 us
module flash_seq_ctrl
	import flash_seq_pkg::*;
#(
	parameter int PROG_TOTAL_CYC = T_PROG_TOTAL_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Device bus
	output logic      [23:0] dev_addr,
	output logic      [15:0] dev_wdata,
	output logic             dev_wr,
	output logic             dev_word,
	output logic             dev_rd,
	input  wire logic [7:0]  dev_rdata
);

	typedef enum logic [21:0] {
		S_IDLE       = 22'h000001, S_HV_ON     = 22'h000002, S_HV_WAIT   = 22'h000004,
		S_SEL_LO     = 22'h000008, S_SEL_HI    = 22'h000010, S_LATCH     = 22'h000020,
		S_WD_ON      = 22'h000040, S_PULSE_ON  = 22'h000080, S_PULSE_WAIT = 22'h000100,
		S_PULSE_OFF  = 22'h000200, S_WD_OFF    = 22'h000400, S_VFY_ON    = 22'h000800,
		S_VFY_WAIT   = 22'h001000, S_DUMMY     = 22'h002000, S_DUMMY_WAIT = 22'h004000,
		S_READ       = 22'h008000, S_READ_WAIT = 22'h010000, S_CHECK     = 22'h020000,
		S_VFY_OFF    = 22'h040000, S_FIN_LO    = 22'h080000, S_FIN_HI    = 22'h100000,
		S_FIN_CTRL   = 22'h200000
	} state_e;

	state_e state_q;
	logic        wreq_q;
	logic [31:0] rdata_q;
	logic [23:0] dev_addr_q;
	logic [15:0] dev_wdata_q;
	logic        dev_wr_q, dev_word_q, dev_rd_q;
	logic [7:0]  rd_s1_q, rd_s2_q, rd_byte_q;
	logic        erase_op_q, prewr_q, done_q, err_q, ok_q;
	logic [23:0] start_q, end_q, addr_q;
	logic [7:0]  data_q;
	logic [15:0] blksel_q, ppulse_q, epulse_q;
	logic [TMR_W-1:0] pulse_len_q;
	logic [19:0] total_q;
	logic [3:0]  pulse_cnt_q;
	logic [9:0]  rep_q;
	logic        tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic        tmr_done;

	// Merge written byte lanes into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave decode
	wire        acc      = (avs_read || avs_write) && !wreq_q;
	wire        wr_acc   = acc && avs_write && (state_q == S_IDLE);
	wire [31:0] wr_cmd   = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
	wire [31:0] wr_start = be_merge({8'h00, start_q}, avs_writedata, avs_byteenable);
	wire [31:0] wr_end   = be_merge({8'h00, end_q}, avs_writedata, avs_byteenable);
	wire [31:0] wr_data  = be_merge({24'h000000, data_q}, avs_writedata, avs_byteenable);
	wire [31:0] wr_blk   = be_merge({16'h0000, blksel_q}, avs_writedata, avs_byteenable);
	wire [31:0] wr_pp    = be_merge({16'h0000, ppulse_q}, avs_writedata, avs_byteenable);
	wire [31:0] wr_ep    = be_merge({16'h0000, epulse_q}, avs_writedata, avs_byteenable);
	wire        busy     = (state_q != S_IDLE);
	wire [31:0] status_w = {6'h00, rep_q, 4'h0, pulse_cnt_q, 5'h00, err_q, done_q, busy};
	wire [31:0] rd_mux   = (avs_address == REG_START)  ? {8'h00, start_q} :
	                       (avs_address == REG_END)    ? {8'h00, end_q} :
	                       (avs_address == REG_DATA)   ? {24'h000000, data_q} :
	                       (avs_address == REG_BLKSEL) ? {16'h0000, blksel_q} :
	                       (avs_address == REG_PPULSE) ? {16'h0000, ppulse_q} :
	                       (avs_address == REG_EPULSE) ? {16'h0000, epulse_q} :
	                       (avs_address == REG_STATUS) ? status_w : 32'h0000_0000;
	wire        go       = wr_acc && (avs_address == REG_CMD) && wr_cmd[CMD_GO];

	// One wait cycle then answer; config refused while busy
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wreq_q   <= 1'b1;
			rdata_q  <= 32'h0000_0000;
			start_q  <= 24'h000000;
			end_q    <= 24'h000000;
			data_q   <= 8'h00;
			blksel_q <= 16'h0000;
			ppulse_q <= PPULSE_RST;
			epulse_q <= EPULSE_RST;
		end else begin
			wreq_q  <= !((avs_read || avs_write) && wreq_q);
			rdata_q <= ((avs_read || avs_write) && wreq_q) ? rd_mux : rdata_q;
			if (wr_acc && avs_address == REG_START) start_q <= wr_start[23:0];
			if (wr_acc && avs_address == REG_END) end_q <= wr_end[23:0];
			if (wr_acc && avs_address == REG_DATA) data_q <= wr_data[7:0];
			if (wr_acc && avs_address == REG_BLKSEL) blksel_q <= wr_blk[15:0];
			if (wr_acc && avs_address == REG_PPULSE) ppulse_q <= wr_pp[15:0];
			if (wr_acc && avs_address == REG_EPULSE) epulse_q <= wr_ep[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase selection and derived values
	wire        is_ers   = erase_op_q && !prewr_q;
	wire [7:0]  pulse_cd = is_ers ? CTRL_ERASE : CTRL_PROG;
	wire [7:0]  vfy_cd   = is_ers ? CTRL_BCHK : CTRL_WCHK;
	wire [7:0]  expect_b = is_ers ? BYTE_BLANK : (erase_op_q ? BYTE_ZERO : data_q);
	wire        match    = (rd_byte_q == expect_b);
	wire [TMR_W-1:0] pp_max  = TMR_W'(T_PROG_MAX_CYC);
	wire [TMR_W-1:0] pp_raw  = {{(TMR_W-16){1'b0}}, ppulse_q};
	wire [TMR_W-1:0] pp_init = (pp_raw > pp_max) ? pp_max : ((pp_raw == '0) ? TMR_W'(1) : pp_raw);
	wire [TMR_W-1:0] ep_len  = (epulse_q == 16'h0000) ? TMR_W'(1) : {{(TMR_W-16){1'b0}}, epulse_q};
	wire [20:0] next_tot = {1'b0, total_q} + {pulse_len_q[19:0], 1'b0};
	wire        tot_over = next_tot > 21'(PROG_TOTAL_CYC);
	wire        last     = (addr_q == end_q);

	// Timer loads on entry to each timed wait
	assign tmr_load  = (state_q == S_HV_ON) || (state_q == S_PULSE_ON) || (state_q == S_VFY_ON) ||
	                   (state_q == S_DUMMY) || (state_q == S_READ);
	assign tmr_count = (state_q == S_HV_ON)    ? TMR_W'(T_HV_CYC) :
	                   (state_q == S_PULSE_ON) ? (is_ers ? ep_len : pulse_len_q) :
	                   (state_q == S_VFY_ON)   ? (is_ers ? TMR_W'(T_BCHK_CYC) : TMR_W'(T_WCHK_CYC)) :
	                   (state_q == S_DUMMY)    ? TMR_W'(T_DUMMY_CYC) : TMR_W'(READ_SETTLE_CYC);

	seq_wait_timer u_timer (
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (tmr_load),
		.count   (tmr_count),
		.done    (tmr_done)
	);

	// Read data pins pass two flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_s1_q <= 8'h00;
			rd_s2_q <= 8'h00;
		end else begin
			rd_s1_q <= dev_rdata;
			rd_s2_q <= rd_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer; each write state issues one device write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			{dev_wr_q, dev_word_q, dev_rd_q} <= 3'b000;
			dev_addr_q <= 24'h000000;
			dev_wdata_q <= 16'h0000;
			{erase_op_q, prewr_q, done_q, err_q, ok_q} <= 5'b00000;
			addr_q <= 24'h000000;
			rd_byte_q <= 8'h00;
			pulse_len_q <= '0;
			total_q <= 20'h00000;
			pulse_cnt_q <= 4'h0;
			rep_q <= 10'h000;
		end else begin
			dev_wr_q <= 1'b0;
			dev_word_q <= 1'b0;
			case (state_q)
				S_IDLE: if (go) begin
					erase_op_q <= wr_cmd[CMD_ERASE];
					prewr_q <= wr_cmd[CMD_ERASE];
					addr_q <= start_q;
					{done_q, err_q} <= 2'b00;
					rep_q <= 10'h000;
					state_q <= S_HV_ON;
				end
				S_HV_ON: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_CTRL, 8'h00, CTRL_HV};
					state_q <= S_HV_WAIT;
				end
				S_HV_WAIT: if (tmr_done) state_q <= S_SEL_LO;
				S_SEL_LO: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_SEL_LO, 8'h00, blksel_q[7:0]};
					state_q <= S_SEL_HI;
				end
				S_SEL_HI: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_SEL_HI, 8'h00, blksel_q[15:8]};
					state_q <= S_LATCH;
				end
				S_LATCH: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, addr_q, 8'h00, expect_b};
					pulse_len_q <= pp_init;
					total_q <= 20'h00000;
					pulse_cnt_q <= 4'h0;
					state_q <= S_WD_ON;
				end
				S_WD_ON: begin
					{dev_wr_q, dev_word_q, dev_addr_q, dev_wdata_q} <= {2'b11, ADDR_WDOG, WDOG_START};
					state_q <= S_PULSE_ON;
				end
				S_PULSE_ON: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_CTRL, 8'h00, pulse_cd};
					if (is_ers) rep_q <= rep_q + 10'h001;
					else begin
						pulse_cnt_q <= pulse_cnt_q + 4'h1;
						total_q <= total_q + pulse_len_q[19:0];
					end
					state_q <= S_PULSE_WAIT;
				end
				S_PULSE_WAIT: if (tmr_done) state_q <= S_PULSE_OFF;
				S_PULSE_OFF: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_CTRL, 8'h00, CTRL_HV};
					state_q <= S_WD_OFF;
				end
				S_WD_OFF: begin
					{dev_wr_q, dev_word_q, dev_addr_q, dev_wdata_q} <= {2'b11, ADDR_WDOG, WDOG_STOP};
					state_q <= S_VFY_ON;
				end
				S_VFY_ON: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_CTRL, 8'h00, vfy_cd};
					state_q <= S_VFY_WAIT;
				end
				S_VFY_WAIT: if (tmr_done) state_q <= is_ers ? S_DUMMY : S_READ;
				S_DUMMY: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, addr_q, 8'h00, BYTE_BLANK};
					state_q <= S_DUMMY_WAIT;
				end
				S_DUMMY_WAIT: if (tmr_done) state_q <= S_READ;
				S_READ: begin
					{dev_rd_q, dev_addr_q} <= {1'b1, addr_q};
					state_q <= S_READ_WAIT;
				end
				S_READ_WAIT: if (tmr_done) begin
					dev_rd_q <= 1'b0;
					rd_byte_q <= rd_s2_q;
					state_q <= S_CHECK;
				end
				S_CHECK: begin
					ok_q <= match;
					if (is_ers && match && !last) begin
						addr_q <= addr_q + 24'h000001;
						state_q <= S_DUMMY;
					end else state_q <= S_VFY_OFF;
				end
				S_VFY_OFF: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_CTRL, 8'h00, CTRL_HV};
					state_q <= S_WD_ON;
					if (is_ers) begin
						if (ok_q) state_q <= S_FIN_LO;
						else if (rep_q == 10'(ERASE_MAX_REPS)) begin
							err_q <= 1'b1;
							state_q <= S_FIN_LO;
						end
					end else if (ok_q) begin
						if (!erase_op_q) state_q <= S_FIN_LO;
						else if (last) begin
							{prewr_q, addr_q} <= {1'b0, start_q};
							state_q <= S_WD_ON;
						end else begin
							addr_q <= addr_q + 24'h000001;
							state_q <= S_LATCH;
						end
					end else if (pulse_cnt_q == 4'(PV_MAX_TRIES) || tot_over) begin
						err_q <= 1'b1;
						state_q <= S_FIN_LO;
					end else pulse_len_q <= {pulse_len_q[TMR_W-2:0], 1'b0};
				end
				S_FIN_LO: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_SEL_LO, 16'h0000};
					state_q <= S_FIN_HI;
				end
				S_FIN_HI: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_SEL_HI, 16'h0000};
					state_q <= S_FIN_CTRL;
				end
				S_FIN_CTRL: begin
					{dev_wr_q, dev_addr_q, dev_wdata_q} <= {1'b1, ADDR_CTRL, 8'h00, CTRL_OFF};
					done_q <= 1'b1;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign avs_waitrequest = wreq_q;
	assign avs_readdata = rdata_q;
	assign dev_addr = dev_addr_q;
	assign dev_wdata = dev_wdata_q;
	assign dev_wr = dev_wr_q;
	assign dev_word = dev_word_q;
	assign dev_rd = dev_rd_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertion helpers: last control code, watchdog, elapsed cycles
	wire ctrl_wr = dev_wr_q && (dev_addr_q == ADDR_CTRL);
	logic [7:0]  last_ctrl_q, last_wbyte_q;
	logic        wd_run_q;
	logic [16:0] since_ctrl_q, since_wr_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{last_ctrl_q, last_wbyte_q, wd_run_q} <= {8'h00, 8'h00, 1'b0};
			{since_ctrl_q, since_wr_q} <= {17'h00000, 17'h00000};
		end else begin
			if (ctrl_wr) last_ctrl_q <= dev_wdata_q[7:0];
			if (dev_wr_q) last_wbyte_q <= dev_wdata_q[7:0];
			if (dev_wr_q && dev_word_q) wd_run_q <= (dev_wdata_q == WDOG_START);
			since_ctrl_q <= ctrl_wr ? 17'h00000 : (since_ctrl_q + {16'h0000, ~&since_ctrl_q});
			since_wr_q <= dev_wr_q ? 17'h00000 : (since_wr_q + {16'h0000, ~&since_wr_q});
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	pv_after_p_a: assert property (ctrl_wr && dev_wdata_q[7:0] == CTRL_WCHK |-> last_ctrl_q == CTRL_HV)
		else $error("write check selected without clearing program");
	pv_wait_a: assert property ($rose(dev_rd_q) && !is_ers |-> since_ctrl_q >= T_WCHK_CYC)
		else $error("write check read too early");
	prog_limit_a: assert property (pulse_cnt_q <= PV_MAX_TRIES && total_q <= PROG_TOTAL_CYC)
		else $error("program retry or total time exceeded");
	pulse_double_a: assert property (state_q == S_VFY_OFF && !is_ers && !ok_q && !err_q ##1 state_q == S_WD_ON
		|-> pulse_len_q == {$past(pulse_len_q[TMR_W-2:0]), 1'b0})
		else $error("pulse length not doubled");
	wdog_guard_a: assert property (ctrl_wr && (dev_wdata_q[7:0] == CTRL_PROG || dev_wdata_q[7:0] == CTRL_ERASE)
		|-> wd_run_q)
		else $error("pulse without watchdog running");
	hv_settle_a: assert property (dev_wr_q && state_q == S_SEL_HI |-> last_ctrl_q == CTRL_HV
		&& since_ctrl_q >= T_HV_CYC)
		else $error("block select before high voltage settled");
	ev_after_e_a: assert property (ctrl_wr && dev_wdata_q[7:0] == CTRL_BCHK |-> last_ctrl_q == CTRL_HV
		##1 (!dev_wr_q && !dev_rd_q) [*8])
		else $error("blank check not entered cleanly");
	bchk_wait_a: assert property (dev_wr_q && is_ers && state_q == S_DUMMY_WAIT |-> since_ctrl_q >= T_BCHK_CYC)
		else $error("dummy write too soon after blank check select");
	dummy_ff_a: assert property ($rose(dev_rd_q) && is_ers |-> last_wbyte_q == BYTE_BLANK)
		else $error("blank read without dummy write");
	dummy_wait_a: assert property ($rose(dev_rd_q) && is_ers |-> since_wr_q >= T_DUMMY_CYC)
		else $error("blank read too soon after dummy write");
	erase_reps_a: assert property (rep_q <= ERASE_MAX_REPS)
		else $error("erase repetitions exceeded");
	first_pulse_a: assert property (ctrl_wr && dev_wdata_q[7:0] == CTRL_HV && last_ctrl_q == CTRL_PROG
		&& pulse_cnt_q == 1 |-> since_ctrl_q <= T_PROG_MAX_CYC)
		else $error("first program pulse too long");

endmodule
`default_nettype wire

// ### testbench/flash_dev_model.sv
// Behavioural flash array and its control registers
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
	import flash_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Device bus
	input  wire logic [23:0] dev_addr,
	input  wire logic [15:0] dev_wdata,
	input  wire logic        dev_wr,
	input  wire logic        dev_word,
	input  wire logic        dev_rd,
	output wire logic [7:0]  dev_rdata,
	// Cell speed and fault count
	input  wire logic [19:0] prog_need,
	input  wire logic [19:0] erase_need,
	output var  logic [7:0]  violations
);
	logic [7:0]  mem [16];
	logic [7:0]  ctrl_q;
	logic [7:0]  lat_data_q;
	logic [7:0]  noise_q;
	logic [15:0] sel_q;
	logic [3:0]  lat_addr_q;
	logic        wdog_q;
	logic        rd_q;
	logic [19:0] prog_acc_q;
	logic [19:0] erase_acc_q;
	logic [19:0] hv_cnt_q;
	logic [19:0] wait_cnt_q;
	logic        dirty;
	// Decode
	wire logic [7:0] wb = dev_wdata[7:0];
	wire logic ctl_wr = dev_wr && dev_addr == ADDR_CTRL;
	wire logic sel_wr = dev_wr && (dev_addr == ADDR_SEL_LO || dev_addr == ADDR_SEL_HI);
	wire logic wd_wr = dev_wr && dev_addr == ADDR_WDOG;
	wire logic fl_wr = dev_wr && dev_addr[23:16] != 8'hFF;
	wire logic pulsing = ctrl_q[BIT_PROG] | ctrl_q[BIT_ERASE];
	wire logic vfy = ctrl_q[BIT_WCHK] | ctrl_q[BIT_BCHK];
	// Unreadable while pulsing, latched cell in verify
	assign dev_rdata = (dev_rd && !pulsing) ? mem[vfy ? lat_addr_q : dev_addr[3:0]] : noise_q;
	// Sequencing faults of the controller
	wire logic bad = (ctl_wr && (wb == CTRL_PROG || wb == CTRL_ERASE) && (ctrl_q != CTRL_HV || !wdog_q))
		|| (ctl_wr && (wb == CTRL_WCHK || wb == CTRL_BCHK) && ctrl_q != CTRL_HV)
		|| (ctl_wr && !(wb inside {CTRL_OFF, CTRL_HV, CTRL_PROG, CTRL_ERASE, CTRL_WCHK, CTRL_BCHK}))
		|| (ctl_wr && wb == CTRL_ERASE && erase_acc_q == 0 && dirty)
		|| (sel_wr && (!ctrl_q[BIT_HV] || hv_cnt_q + 1 < T_HV_CYC))
		|| (wd_wr && (!dev_word || (dev_wdata == WDOG_STOP && pulsing)))
		|| (fl_wr && ctrl_q[BIT_BCHK] && wb != BYTE_BLANK)
		|| (dev_rd && !rd_q && (pulsing || (vfy && wait_cnt_q + 1 < (ctrl_q[BIT_WCHK] ? T_WCHK_CYC : T_DUMMY_CYC))));
	// Any cell not yet prewritten
	always_comb begin
		dirty = 1'b0;
		for (int i = 0; i < 16; i++) dirty |= mem[i] != BYTE_ZERO;
	end
	// Registers, latches and cells
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) mem[i] <= 8'hC3 ^ 8'(i);
			ctrl_q <= CTRL_OFF;
			sel_q <= 16'h0000;
			lat_addr_q <= 4'h0;
			lat_data_q <= 8'hFF;
			noise_q <= 8'h5A;
			wdog_q <= 1'b0;
			rd_q <= 1'b0;
			prog_acc_q <= 20'h00000;
			erase_acc_q <= 20'h00000;
			hv_cnt_q <= 20'h00000;
			wait_cnt_q <= 20'h00000;
			violations <= 8'h00;
		end else begin
			noise_q <= noise_q + 8'h5B; // Released bus changes each cycle
			rd_q <= dev_rd;
			hv_cnt_q <= ctrl_q[BIT_HV] ? hv_cnt_q + 1 : 20'h00000;
			wait_cnt_q <= (ctl_wr || fl_wr) ? 20'h00000 : wait_cnt_q + 1;
			prog_acc_q <= fl_wr ? 20'h00000 : prog_acc_q + 20'(ctrl_q[BIT_PROG]);
			erase_acc_q <= erase_acc_q + 20'(ctrl_q[BIT_ERASE]);
			violations <= violations + 8'(bad);
			if (ctl_wr) ctrl_q <= wb;
			if (sel_wr) sel_q <= dev_addr[0] ? {wb, sel_q[7:0]} : {sel_q[15:8], wb};
			if (wd_wr) wdog_q <= dev_wdata == WDOG_START;
			if (fl_wr && ctrl_q[BIT_HV]) begin
				lat_addr_q <= dev_addr[3:0];
				lat_data_q <= wb;
			end
			if (ctl_wr && ctrl_q[BIT_PROG] && !wb[BIT_PROG] && prog_acc_q >= prog_need)
				mem[lat_addr_q] <= mem[lat_addr_q] & lat_data_q;
			if (ctl_wr && ctrl_q[BIT_ERASE] && !wb[BIT_ERASE] && erase_acc_q >= erase_need && sel_q != 0) begin
				for (int i = 0; i < 16; i++) mem[i] <= BYTE_BLANK;
				erase_acc_q <= 20'h00000;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/flash_program_erase_verify_test.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_verify_test
	import flash_seq_pkg::*;
;
	localparam int TOTAL = 4000;
	localparam int LIMIT = 90000;
	logic        clk_sys;
	logic        rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [23:0] dev_addr;
	logic [15:0] dev_wdata;
	logic        dev_wr;
	logic        dev_word;
	logic        dev_rd;
	logic [7:0]  dev_rdata;
	logic [19:0] prog_need;
	logic [19:0] erase_need;
	logic [7:0]  violations;
	int          fail_count;
	int          comparisons;
	int          cycles;
	flash_seq_ctrl #(.PROG_TOTAL_CYC(TOTAL)) u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_word(dev_word), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
	flash_dev_model u_dev (.clk_sys(clk_sys), .rst(rst), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_wr(dev_wr), .dev_word(dev_word), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
		.prog_need(prog_need), .erase_need(erase_need), .violations(violations));
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Avalon accesses held until waitrequest is seen low
	task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic wait_idle(output logic [31:0] st);
		do av_rd(REG_STATUS, st); while (st[ST_BUSY] !== 1'b0);
	endtask
	// One byte programmed, outcome judged
	task automatic prog(input logic [3:0] a, input logic [7:0] d, input logic [15:0] pulse,
		input logic [19:0] need, input logic err, input logic [3:0] cnt);
		logic [31:0] st;
		logic [7:0]  exp;
		exp = err ? u_dev.mem[a] : u_dev.mem[a] & d;
		prog_need <= need;
		av_wr(REG_START, 32'(a));
		av_wr(REG_DATA, 32'(d));
		av_wr(REG_BLKSEL, 32'h0000_0001);
		av_wr(REG_PPULSE, 32'(pulse));
		av_wr(REG_CMD, 32'h0000_0001);
		wait_idle(st);
		check(32'(st[ST_ERR]), 32'(err));
		check(32'(st[ST_DONE]), 32'h0000_0001);
		check(32'(st[11:8]), 32'(cnt));
		check(32'(u_dev.mem[a]), 32'(exp));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic regs_after_reset();
		logic [31:0] v;
		av_rd(REG_PPULSE, v);
		check(v, 32'h0000_0100);
		av_rd(REG_EPULSE, v);
		check(v, 32'h0000_1000);
		av_rd(REG_STATUS, v);
		check(v, 32'h0000_0000);
		av_wr(5'h02, 32'hFFFF_FFFF);
		av_rd(5'h02, v);
		check(v, 32'h0000_0000);
	endtask
	task automatic prog_first_try();
		prog(4'h3, 8'h40, 16'h0008, 20'h00004, 1'b0, 4'h1);
	endtask
	task automatic prog_retries();
		prog(4'h5, 8'h06, 16'h0008, 20'h00028, 1'b0, 4'h3);
	endtask
	task automatic prog_limits();
		prog(4'h6, 8'h00, 16'h0008, 20'hFFFFF, 1'b1, 4'h6);
		prog(4'h7, 8'h00, 16'h03E8, 20'hFFFFF, 1'b1, 4'h2);
	endtask
	task automatic erase_all();
		logic [31:0] st;
		logic [31:0] v;
		prog_need <= 20'h00004;
		erase_need <= 20'h00028;
		av_wr(REG_START, 32'h0000_0000);
		av_wr(REG_END, 32'h0000_000F);
		av_wr(REG_PPULSE, 32'h0000_0008);
		av_wr(REG_EPULSE, 32'h0000_0010);
		av_wr(REG_DATA, 32'h0000_0011);
		av_wr(REG_CMD, 32'h0000_0003);
		av_wr(REG_DATA, 32'h0000_0077);
		av_rd(REG_DATA, v);
		check(v, 32'h0000_0011);
		wait_idle(st);
		check(32'(st[ST_ERR]), 32'h0000_0000);
		check(32'(st[ST_DONE]), 32'h0000_0001);
		check(32'(st[25:16]), 32'h0000_0003);
		for (int i = 0; i < 16; i++) check(32'(u_dev.mem[i]), 32'h0000_00FF);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		prog_need = 20'h00004;
		erase_need = 20'h00028;
		fail_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		regs_after_reset();
		prog_first_try();
		prog_retries();
		prog_limits();
		erase_all();
		check(32'(violations), 32'h0000_0000);
		test_done();
	end
endmodule
`default_nettype wire
